/* File: hw/psa_pkg.sv */
// Package for the program space access unit
// Summary of operation
// - 24-bit program addresses; fetch uses 23-bit counter
// - Program words step by two
// - Non-table accesses limited to user range
// - Table page top bit picks configuration space
// - Bit 23 set only for configuration accesses
// - Low word table read returns bits 15:0
// - Low byte read picks byte by select
// - High word read zero-extends bits 23:16
// - High byte read: select 1 gives zero
// - Upper byte reachable only by high table ops
// - Upper data half maps onto any page
// - Redirect when address MSB and enable set
// - Visibility address: page, low 15 bits, bit23 zero
// - Visibility read returns low 16 bits
// - Outside loop: one or two extra cycles
// - Loop edges cost two cycles
// - Middle loop iterations take one cycle
// - Upper data half always in X space
// - Y inside X, contiguous linear range
package psa_pkg;
    localparam int PA_W = 24;
    localparam int PC_W = 23;
    localparam int EFF_ADDR_W = 16;
    localparam int PAGE_W = 8;
    localparam logic [23:0] USER_MAX = 24'h7FFFFE;
    localparam logic [23:0] WORD_STEP = 24'h000002;
    localparam int CFG_BIT = 7;
    localparam int EFF_ADDR_MSB = 15;
    localparam int VIS_LOW_W = 15;
    localparam int CORE_VIS_EN_BIT = 2;
    localparam logic [1:0] EXTRA_SHORT = 2'h1;
    localparam logic [1:0] EXTRA_LONG = 2'h2;
    // Register byte addresses
    localparam logic [3:0] ADDR_TBLPAGE = 4'h0;
    localparam logic [3:0] ADDR_VISPAGE = 4'h4;
    localparam logic [3:0] ADDR_CORE = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam logic [7:0] TBLPAGE_RST = 8'h00;
    localparam logic [7:0] VISPAGE_RST = 8'h00;
    localparam logic [15:0] CORE_RST = 16'h0000;
    typedef enum logic [2:0] {
        OP_NONE, OP_FETCH, OP_DATA, OP_TBL_RDL, OP_TBL_RDH, OP_TBL_WTL, OP_TBL_WTH
    } psa_op_t;
    typedef struct packed {
        psa_op_t op;
        logic [PC_W-1:0] pc;
        logic [EFF_ADDR_W-1:0] effective_address;
        logic byte_op;
        logic short_class;
        logic in_repeat;
        logic rpt_edge;
        logic [15:0] wdata;
    } psa_req_t;
    typedef struct packed {
        logic [PA_W-1:0] addr;
        logic rd;
        logic wr_lo;
        logic wr_hi;
        logic [15:0] wdata;
    } psa_mem_t;
endpackage

/* File: hw/psa_addr_gen.sv */
// Program address builder
`timescale 1ns/10ps
`default_nettype none
module psa_addr_gen
    import psa_pkg::*;
(
    // Request
    input wire psa_pkg::psa_op_t op,
    input wire logic [psa_pkg::PC_W-1:0] pc,
    input wire logic [psa_pkg::EFF_ADDR_W-1:0] effective_address,
    // Page state
    input wire logic [7:0] tbl_page,
    input wire logic [7:0] vis_page,
    input wire logic vis_en,
    // Result
    output logic [psa_pkg::PA_W-1:0] addr,
    output logic to_prog,
    output logic in_range
);
    always_comb begin
        to_prog = 1'b0;
        addr = '0;
        case (op)
            OP_FETCH: begin
                addr = {1'b0, pc[22:1], 1'b0};
                to_prog = 1'b1;
            end
            OP_TBL_RDL, OP_TBL_RDH, OP_TBL_WTL, OP_TBL_WTH: begin
                addr = {tbl_page, effective_address};
                to_prog = 1'b1;
            end
            OP_DATA: begin // Data addresses form one linear range
                // Upper data half is X space, so only X accesses reach here
                if (effective_address[EFF_ADDR_MSB] && vis_en) begin
                    addr = {1'b0, vis_page, effective_address[VIS_LOW_W-1:0]};
                    to_prog = 1'b1;
                end
            end
            default: begin
                addr = '0;
            end
        endcase
        // Tables may reach configuration space, everything else stays in user range
        in_range = (op inside {OP_TBL_RDL, OP_TBL_RDH, OP_TBL_WTL, OP_TBL_WTH}) ||
                   (addr <= USER_MAX);
    end
endmodule
`default_nettype wire

/* File: hw/psa_lane_mux.sv */
// Program word to data lane mapping
`timescale 1ns/10ps
`default_nettype none
module psa_lane_mux
    import psa_pkg::*;
(
    // Selection
    input wire psa_pkg::psa_op_t op,
    input wire logic byte_op,
    input wire logic byte_sel,
    // Program word
    input wire logic [23:0] pword,
    // Data out
    output logic [15:0] dout
);
    always_comb begin
        case (op)
            OP_TBL_RDL: begin
                if (!byte_op) begin
                    dout = pword[15:0];
                end else begin
                    dout = {8'h00, byte_sel ? pword[15:8] : pword[7:0]};
                end
            end
            OP_TBL_RDH: begin
                if (!byte_op || !byte_sel) begin
                    dout = {8'h00, pword[23:16]};
                end else begin
                    dout = 16'h0000;
                end
            end
            OP_DATA: dout = pword[15:0];
            default: dout = 16'h0000;
        endcase
    end
endmodule
`default_nettype wire

/* File: hw/psa_top.sv */
// Program space access unit with AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
module psa_top
    import psa_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pipeline request
    input wire logic req_valid,
    input wire psa_pkg::psa_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_fault,
    output logic stall,
    // Program memory
    output var psa_pkg::psa_mem_t mem,
    input wire logic [23:0] mem_rdata,
    // AXI4-Lite
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_WAIT} psa_state_t;

    psa_state_t st_q, st_d;
    psa_req_t cur_q, cur_d;
    logic [1:0] cnt_q, cnt_d;
    logic [7:0] tbl_q, tbl_d, vis_q, vis_d;
    logic [15:0] core_q, core_d;
    logic [31:0] nreq_q, nreq_d;
    logic req_ready_q, req_ready_d, rsp_valid_q, rsp_valid_d, fault_q, fault_d, stall_q, stall_d;
    logic [15:0] rsp_data_q, rsp_data_d;
    psa_mem_t mem_q, mem_d;
    logic [23:0] addr;
    logic to_prog, in_range;
    logic [15:0] lane;

    psa_addr_gen u_addr (
        .op(cur_q.op),
        .pc(cur_q.pc),
        .effective_address(cur_q.effective_address),
        .tbl_page(tbl_q),
        .vis_page(vis_q),
        .vis_en(core_q[CORE_VIS_EN_BIT]),
        .addr(addr),
        .to_prog(to_prog),
        .in_range(in_range)
    );

    psa_lane_mux u_lane (
        .op(cur_q.op),
        .byte_op(cur_q.byte_op),
        .byte_sel(cur_q.effective_address[0]),
        .pword(mem_rdata),
        .dout(lane)
    );

    // Extra cycles of a visibility access
    function automatic logic [1:0] vis_extra(input psa_req_t r);
        logic [1:0] n;
        n = EXTRA_LONG;
        if (r.in_repeat && !r.rpt_edge) begin
            n = 2'h0;
        end else if (r.in_repeat) begin
            n = EXTRA_LONG;
        end else if (r.short_class) begin
            n = EXTRA_SHORT;
        end
        return n;
    endfunction

    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        cnt_d = cnt_q;
        nreq_d = nreq_q;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        fault_d = fault_q;
        stall_d = 1'b0;
        req_ready_d = 1'b0;
        mem_d = '0;
        case (st_q)
            ST_IDLE: begin
                req_ready_d = 1'b1;
                if (req_valid && req_ready_q) begin
                    cur_d = req;
                    st_d = ST_MEM;
                    req_ready_d = 1'b0;
                    stall_d = 1'b1;
                    nreq_d = nreq_q + 32'h1;
                end
            end
            ST_MEM: begin
                stall_d = 1'b1;
                fault_d = !in_range;
                if (!in_range) begin
                    rsp_data_d = 16'h0000;
                    rsp_valid_d = 1'b1;
                    stall_d = 1'b0;
                    st_d = ST_IDLE;
                    req_ready_d = 1'b1;
                end else begin
                    mem_d.addr = addr;
                    mem_d.rd = to_prog && !(cur_q.op inside {OP_TBL_WTL, OP_TBL_WTH});
                    mem_d.wr_lo = (cur_q.op == OP_TBL_WTL);
                    mem_d.wr_hi = (cur_q.op == OP_TBL_WTH);
                    mem_d.wdata = cur_q.wdata;
                    cnt_d = (cur_q.op == OP_DATA && to_prog) ? vis_extra(cur_q) : 2'h0;
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // The word stands only while the read strobe does; extra cycles only hold back the answer
                if (mem_q.rd) begin
                    rsp_data_d = lane;
                end
                if (cnt_q != 2'h0) begin
                    cnt_d = cnt_q - 2'h1;
                    stall_d = 1'b1;
                end else begin
                    rsp_valid_d = 1'b1;
                    st_d = ST_IDLE;
                    req_ready_d = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
            cur_q <= '0;
            cnt_q <= 2'h0;
            nreq_q <= 32'h0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
            fault_q <= 1'b0;
            stall_q <= 1'b0;
            req_ready_q <= 1'b0;
            mem_q <= '0;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            cnt_q <= cnt_d;
            nreq_q <= nreq_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            fault_q <= fault_d;
            stall_q <= stall_d;
            req_ready_q <= req_ready_d;
            mem_q <= mem_d;
        end
    end

    assign req_ready = req_ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign rsp_fault = fault_q;
    assign stall = stall_q;
    assign mem = mem_q;

    // AXI4-Lite slave with registered readies; one write and one read in flight at most
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, ar_q, ar_d, rv_q, rv_d, awrdy_q, awrdy_d, wrdy_q, wrdy_d;
    logic [3:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0] ws_q, ws_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        tbl_d = tbl_q;
        vis_d = vis_q;
        core_d = core_q;
        ar_d = ar_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_awvalid && awrdy_q) begin
            aw_d = 1'b1;
            awa_d = s_awaddr;
        end
        if (s_wvalid && wrdy_q) begin
            w_d = 1'b1;
            wd_d = s_wdata;
            ws_d = s_wstrb;
        end
        if (aw_q && w_q) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = 2'b00;
            case ({awa_q[3:2], 2'b00})
                ADDR_TBLPAGE: if (ws_q[0]) tbl_d = wd_q[7:0];
                ADDR_VISPAGE: if (ws_q[0]) vis_d = wd_q[7:0];
                ADDR_CORE: begin
                    if (ws_q[0]) core_d[7:0] = wd_q[7:0];
                    if (ws_q[1]) core_d[15:8] = wd_q[15:8];
                end
                ADDR_STATUS: br_d = 2'b00;
                default: br_d = 2'b10;
            endcase
        end
        if (bv_q && s_bready) begin
            bv_d = 1'b0;
        end
        if (s_arvalid && ar_q) begin
            rv_d = 1'b1;
            rr_d = 2'b00;
            case ({s_araddr[3:2], 2'b00})
                ADDR_TBLPAGE: rd_d = {24'h000000, tbl_q};
                ADDR_VISPAGE: rd_d = {24'h000000, vis_q};
                ADDR_CORE: rd_d = {16'h0000, core_q};
                ADDR_STATUS: rd_d = {nreq_q[27:0], fault_q, stall_q, st_q};
                default: begin
                    rd_d = 32'h00000000;
                    rr_d = 2'b10;
                end
            endcase
        end
        if (rv_q && s_rready) begin
            rv_d = 1'b0;
        end
        // Each slot reopens as its response is taken, so read data never precedes its address
        awrdy_d = !aw_d && !bv_d;
        wrdy_d = !w_d && !bv_d;
        ar_d = !rv_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            awrdy_q <= 1'b0;
            wrdy_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 4'h0;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= 2'b00;
            tbl_q <= TBLPAGE_RST;
            vis_q <= VISPAGE_RST;
            core_q <= CORE_RST;
            ar_q <= 1'b0;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rr_q <= 2'b00;
        end else begin
            aw_q <= aw_d;
            awrdy_q <= awrdy_d;
            wrdy_q <= wrdy_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            tbl_q <= tbl_d;
            vis_q <= vis_d;
            core_q <= core_d;
            ar_q <= ar_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
        end
    end

    assign s_awready = awrdy_q;
    assign s_wready = wrdy_q;
    assign s_bvalid = bv_q;
    assign s_bresp = br_q;
    assign s_arready = ar_q;
    assign s_rvalid = rv_q;
    assign s_rdata = rd_q;
    assign s_rresp = rr_q;

    // Assertions
    property p_fetch_addr;
        @(posedge aclk) disable iff (!aresetn)
        mem.rd && $past(cur_q.op) == OP_FETCH |-> mem.addr[23] == 1'b0 && mem.addr[0] == 1'b0;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address bit 23 or 0 set");
    property p_range;
        @(posedge aclk) disable iff (!aresetn)
        (mem.rd || mem.wr_lo) && !$past(cur_q.op inside {OP_TBL_RDL, OP_TBL_RDH, OP_TBL_WTL}) |->
        mem.addr <= USER_MAX;
    endproperty
    a_range: assert property (p_range) else $error("access outside user range");
    property p_vis_addr;
        @(posedge aclk) disable iff (!aresetn)
        mem.rd && $past(cur_q.op) == OP_DATA |->
        mem.addr[23] == 1'b0 && mem.addr[14:0] == $past(cur_q.effective_address[14:0]);
    endproperty
    a_vis_addr: assert property (p_vis_addr) else $error("visibility address wrong");
    property p_short;
        @(posedge aclk) disable iff (!aresetn)
        mem.rd && $past(cur_q.op) == OP_DATA && $past(cur_q.short_class) && !$past(cur_q.in_repeat) |->
        !rsp_valid ##1 !rsp_valid ##1 rsp_valid;
    endproperty
    a_short: assert property (p_short) else $error("short class extra cycle wrong");
    property p_long;
        @(posedge aclk) disable iff (!aresetn)
        mem.rd && $past(cur_q.op) == OP_DATA && $past(cur_q.in_repeat) && $past(cur_q.rpt_edge) |->
        !rsp_valid [*3] ##1 rsp_valid;
    endproperty
    a_long: assert property (p_long) else $error("loop edge extra cycles wrong");
    property p_single;
        @(posedge aclk) disable iff (!aresetn)
        mem.rd && $past(cur_q.op) == OP_DATA && $past(cur_q.in_repeat) && !$past(cur_q.rpt_edge) |->
        ##1 rsp_valid;
    endproperty
    a_single: assert property (p_single) else $error("loop middle not single cycle");
    property p_stall;
        @(posedge aclk) disable iff (!aresetn)
        st_q == ST_WAIT && cnt_q != 2'h0 |=> stall && !rsp_valid;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall during extra fetch");
    property p_rdh;
        @(posedge aclk) disable iff (!aresetn)
        st_q == ST_WAIT && cnt_q == 2'h0 && cur_q.op == OP_TBL_RDH |=> rsp_data[15:8] == 8'h00;
    endproperty
    a_rdh: assert property (p_rdh) else $error("high read upper byte not zero");
    c_fetch: cover property (@(posedge aclk) mem.rd && $past(cur_q.op) == OP_FETCH);
    c_vis: cover property (@(posedge aclk) mem.rd && $past(cur_q.op) == OP_DATA);
    c_tbl: cover property (@(posedge aclk) mem.wr_hi);
endmodule
`default_nettype wire

/* File: testbench/psa_mem_model.sv */
// Behavioural program memory on the far side of the access unit
`timescale 1ns/10ps
`default_nettype none
module psa_mem_model
    import psa_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Memory port
    input wire psa_pkg::psa_mem_t mem,
    output logic [23:0] mem_rdata
);
    import psa_pkg::*;
    logic [23:0] words [logic [23:0]];
    logic [23:0] w;
    logic [23:0] junk_q = 24'h5A5A5A;
    // Read data stands only while the read strobe does; otherwise it toggles so late sampling shows
    always @(mem or junk_q) begin
        if (!mem.rd) begin
            mem_rdata = junk_q;
        end else if (words.exists(mem.addr)) begin
            mem_rdata = words[mem.addr];
        end else begin
            mem_rdata = {mem.addr[7:0] ^ 8'h5A, mem.addr[15:0] ^ 16'hC3A5};
        end
    end
    always @(posedge aclk) begin
        junk_q <= ~junk_q;
        w = words.exists(mem.addr) ? words[mem.addr] : {mem.addr[7:0] ^ 8'h5A, mem.addr[15:0] ^ 16'hC3A5};
        if (mem.wr_lo) begin
            w[15:0] = mem.wdata;
        end
        if (mem.wr_hi) begin
            w[23:16] = mem.wdata[7:0];
        end
        if (mem.wr_lo || mem.wr_hi) begin
            words[mem.addr] = w;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the program space access unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import psa_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, req_valid = 1'b0;
    psa_req_t req = '0;
    logic req_ready, rsp_valid, rsp_fault, stall, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [15:0] rsp_data;
    psa_mem_t mem;
    logic [23:0] mem_rdata;
    logic [3:0] s_awaddr = 4'h0, s_wstrb = 4'hF, s_araddr = 4'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic [31:0] s_wdata = 32'h00000000, s_rdata, rd_val;
    logic [1:0] s_bresp, s_rresp, rd_resp;
    int miscompares = 0, n_tests = 0, g_lat;
    logic g_rd, g_wlo, g_whi, g_stall, g_fault;
    logic [23:0] g_addr;
    logic [15:0] g_data, g_wdata;
    always #10 aclk = ~aclk;
    psa_top u_psa_top (.aclk(aclk), .aresetn(aresetn), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fault(rsp_fault),
        .stall(stall), .mem(mem), .mem_rdata(mem_rdata), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
    psa_mem_model u_psa_mem_model (.aclk(aclk), .mem(mem), .mem_rdata(mem_rdata));
    function automatic logic [23:0] pat(input logic [23:0] a);
        return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'hC3A5};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        summarize();
    endtask
    // Both channels offered together, each dropped once taken; response ends the write
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, wt, b;
        @(posedge aclk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= d;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            aw = s_awvalid && s_awready;
            wt = s_wvalid && s_wready;
            b = s_bvalid;
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (wt) s_wvalid <= 1'b0;
            if (b) begin
                s_bready <= 1'b0;
                chk(s_bresp, 2'h0);
                return;
            end
        end
        hang();
    endtask
    task automatic axi_rd(input logic [3:0] a);
        logic ar;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ar = s_arvalid && s_arready;
            rd_val = s_rdata;
            rd_resp = s_rresp;
            @(posedge aclk);
            if (ar) s_arvalid <= 1'b0;
            if (s_rvalid) begin
                s_rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask
    // One pipeline request; records latency from the take edge and what reached memory
    task automatic run(input psa_req_t r);
        int n;
        g_rd = 1'b0;
        g_wlo = 1'b0;
        g_whi = 1'b0;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        if (req_ready !== 1'b1) begin
            hang();
        end
        @(posedge aclk);
        req_valid <= 1'b1;
        req <= r;
        @(posedge aclk);
        req_valid <= 1'b0;
        for (g_lat = 1; g_lat < 20; g_lat++) begin
            @(negedge aclk);
            if (mem.rd || mem.wr_lo || mem.wr_hi) begin
                g_addr = mem.addr;
                g_wdata = mem.wdata;
                g_stall = stall;
            end
            g_rd |= mem.rd;
            g_wlo |= mem.wr_lo;
            g_whi |= mem.wr_hi;
            if (rsp_valid) begin
                g_data = rsp_data;
                g_fault = rsp_fault;
                return;
            end
        end
        hang();
    endtask
    task automatic test_regs();
        for (int i = 0; i < 3; i++) begin
            axi_rd(4'(4 * i));
            chk(rd_val, 32'h00000000);
            chk(rd_resp, 2'h0);
        end
        axi_wr(ADDR_VISPAGE, 32'h000000C3);
        axi_rd(ADDR_VISPAGE);
        chk(rd_val, 32'h000000C3);
        $display("registers done");
    endtask
    task automatic test_fetch();
        logic [22:0] pcs [4] = '{23'h000000, 23'h000002, 23'h7FFFFF, 23'h2AAAAB};
        psa_req_t r;
        r = '0;
        r.op = OP_FETCH;
        foreach (pcs[i]) begin
            r.pc = pcs[i];
            run(r);
            chk(g_addr, {1'b0, pcs[i][22:1], 1'b0});
            chk({g_rd, g_fault, g_stall}, 3'b101);
            chk(g_lat, 3);
        end
        $display("fetch done");
    endtask
    task automatic test_table_rd();
        logic [7:0] pg [2] = '{8'h00, 8'h80};
        logic [23:0] p, a;
        psa_req_t r;
        r = '0;
        foreach (pg[k]) begin
            axi_wr(ADDR_TBLPAGE, {24'h000000, pg[k]});
            for (int i = 0; i < 6; i++) begin
                r.op = (i < 3) ? OP_TBL_RDL : OP_TBL_RDH;
                r.byte_op = (i % 3) != 0;
                r.effective_address = (i % 3 == 2) ? 16'h1235 : 16'h1234;
                a = {pg[k], r.effective_address};
                p = pat(a);
                run(r);
                chk(g_addr, a);
                chk(g_addr[23], pg[k][7]);
                chk(g_lat, 3);
                case (i)
                    0: chk(g_data, p[15:0]);
                    1: chk(g_data[7:0], p[7:0]);
                    2: chk(g_data[7:0], p[15:8]);
                    3: chk(g_data, {8'h00, p[23:16]});
                    4: chk(g_data[7:0], p[23:16]);
                    default: chk(g_data[7:0], 8'h00);
                endcase
            end
        end
        $display("table read done");
    endtask
    task automatic test_table_wr();
        psa_req_t r;
        axi_wr(ADDR_TBLPAGE, 32'h00000001);
        r = '0;
        r.effective_address = 16'h0040;
        r.op = OP_TBL_WTL;
        r.wdata = 16'hBEEF;
        run(r);
        chk({g_wlo, g_whi, g_wdata}, {2'b10, 16'hBEEF});
        chk(g_addr, 24'h010040);
        r.op = OP_TBL_WTH;
        r.wdata = 16'h0077;
        run(r);
        chk({g_wlo, g_whi, g_wdata[7:0]}, 10'b01_0111_0111);
        r.op = OP_TBL_RDH;
        run(r);
        chk(g_data, 16'h0077);
        r.op = OP_TBL_RDL;
        run(r);
        chk(g_data, 16'hBEEF);
        $display("table write done");
    endtask
    task automatic test_vis();
        psa_req_t r;
        int ex;
        logic [23:0] p;
        r = '0;
        r.op = OP_DATA;
        axi_wr(ADDR_CORE, 32'h00000004);
        for (int i = 0; i < 8; i++) begin
            {r.rpt_edge, r.in_repeat, r.short_class} = 3'(i);
            r.effective_address = 16'h8006 + 16'(2 * i);
            ex = !r.in_repeat ? (r.short_class ? 1 : 2) : (r.rpt_edge ? 2 : 0);
            p = pat({1'b0, 8'hC3, r.effective_address[14:0]});
            run(r);
            chk(g_addr, {1'b0, 8'hC3, r.effective_address[14:0]});
            chk(g_data, p[15:0]);
            chk(g_lat, 3 + ex);
            chk({g_rd, g_stall}, 2'b11);
        end
        axi_wr(ADDR_VISPAGE, 32'h000000FF);
        r.effective_address = 16'hFFFE;
        run(r);
        chk(g_addr, 24'h7FFFFE);
        r.effective_address = 16'hFFFF;
        run(r);
        chk({g_fault, g_data}, 17'h10000);
        chk(g_lat, 2);
        r.effective_address = 16'h7FFE;
        run(r);
        chk(g_rd, 1'b0);
        axi_wr(ADDR_CORE, 32'h00000000);
        r.effective_address = 16'h8006;
        run(r);
        chk(g_rd, 1'b0);
        chk(g_lat, 3);
        $display("visibility done");
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        test_regs();
        test_fetch();
        test_table_rd();
        test_table_wr();
        test_vis();
        summarize();
    end
endmodule
`default_nettype wire
